// >>> hdl/cpu_flags_pkg.sv
/*
  Shared constants and types for the condition-flag and data-addressing block:
  flag positions, reset value, internal register addresses, operation codes.
  Assumes a 14-bit linear data space and an 8-bit data path.
*/
package cpu_flags_pkg;

  // flag bit positions
  localparam int FLAG_C      = 0;
  localparam int FLAG_DC     = 1;
  localparam int FLAG_Z      = 2;
  localparam int FLAG_OV     = 3;
  localparam int FLAG_N      = 4;
  localparam int FLAG_PD     = 5;
  localparam int FLAG_TO     = 6;
  localparam int FLAG_UNUSED = 7;

  localparam logic [7:0] FLAGS_RESET   = 8'h60;
  localparam logic [7:0] FLAGS_SW_MASK = 8'h1f;
  localparam logic [7:0] MASK_ARITH    = 8'h1f;
  localparam logic [7:0] MASK_LOGIC    = 8'h14;
  localparam logic [7:0] MASK_ROTATE   = 8'h15;
  localparam logic [7:0] MASK_NONE     = 8'h00;

  localparam int         BANK_BITS      = 6;
  localparam int         NUM_PTRS       = 3;
  localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
  localparam logic [5:0] ACCESS_LO_BANK = 6'h00;
  localparam logic [5:0] ACCESS_HI_BANK = 6'h3f;

  // internal register addresses
  localparam logic [13:0] ADDR_BANK        = 14'h3fd8;
  localparam logic [13:0] ADDR_WORK        = 14'h3fd9;
  localparam logic [13:0] ADDR_FLAGS       = 14'h3fda;
  localparam logic [13:0] ADDR_SAVED_FLAGS = 14'h3fdb;
  localparam logic [13:0] ADDR_SAVED_WORK  = 14'h3fdc;
  localparam logic [13:0] ADDR_SAVED_BANK  = 14'h3fdd;

  // pointer blocks: 14'h3fc0 + 8*n, n = 0..2, offsets below
  localparam logic [8:0] PTR_REGION   = 9'h1fe;
  localparam logic [1:0] PTR_NONE_IDX = 2'd3;
  localparam logic [2:0] PTR_OFS_LO   = 3'd0;
  localparam logic [2:0] PTR_OFS_HI   = 3'd1;
  localparam logic [2:0] PTR_OFS_IND  = 3'd2;
  localparam logic [2:0] PTR_OFS_PINC = 3'd3;
  localparam logic [2:0] PTR_OFS_PDEC = 3'd4;
  localparam logic [2:0] PTR_OFS_PRE  = 3'd5;
  localparam logic [2:0] PTR_OFS_WOFS = 3'd6;

  typedef enum logic [3:0] {
    FN_MOVF  = 4'h0, FN_ADD  = 4'h1, FN_SUB  = 4'h2, FN_AND  = 4'h3,
    FN_IOR   = 4'h4, FN_XOR  = 4'h5, FN_CLR  = 4'h6, FN_RLC  = 4'h7,
    FN_RRC   = 4'h8, FN_SWAP = 4'h9, FN_BSF  = 4'ha, FN_BCF  = 4'hb,
    FN_MOVWF = 4'hc, FN_CALL = 4'hd, FN_GOTO = 4'he, FN_NOP  = 4'hf
  } alu_fn_type;

  typedef enum logic [1:0] {
    ADJ_NONE = 2'b00, ADJ_INC = 2'b01, ADJ_DEC = 2'b10
  } ptr_adj_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_READ = 2'b01, ST_EXEC = 2'b10
  } core_state_type;

  typedef struct packed {
    logic        valid;
    alu_fn_type  fn;
    logic [7:0]  f_addr;
    logic        access_sel;
    logic        long_en;
    logic [13:0] long_addr;
    logic        dest_f;
    logic        literal_en;
    logic [7:0]  literal;
    logic [2:0]  bit_sel;
    logic [19:0] target;
    logic        wdt_clear;
    logic        sleep;
  } op_type;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } mem_req_type;

endpackage : cpu_flags_pkg

// >>> hdl/cpu_status_flags_and_data_addressing.sv
/*
  Core condition flags, call save, and data address formation (direct, banked,
  access bank, long, indirect through three pointers) with destination select.
  Assumes a data memory that returns read data one cycle after o_mem.rd and a
  decoder that presents one operation at a time while o_busy is low.
// Contract
// - alu op targeting flags register drops result, flags follow the op
// - call copies working, bank and flags into readable saved registers
// - flags bit 7 does not exist and reads zero
// - timeout flag set by reset, clear-watchdog, sleep; cleared on expiry
// - power-down flag set by reset and clear-watchdog; cleared by sleep
// - negative flag equals result bit 7
// - overflow flag marks a wrong sign change in signed arithmetic
// - zero flag set when result is zero, else cleared
// - digit carry is the carry out of bit 3 for add and subtract
// - carry is the carry out of bit 7 for add and subtract
// - subtract adds the two's complement, carries act as inverted borrows
// - rotate through carry loads carry with the bit shifted out
// - call and goto carry a 20-bit program target
// - byte and bit ops carry an 8-bit register address
// - access-select one joins bank select with the 8-bit address
// - access-select zero maps the 8-bit address into the access bank
// - long-address ops use the 14-bit address, bank select ignored
// - destination bit one writes the source register, zero writes working
// - three pointer pairs of two bytes hold 14-bit addresses
// - indirect operand accesses the location its pointer holds
// - indirect target ignores bank select and access-select
// - post-dec, post-inc, pre-inc and working-offset operands per pointer
// - pointer steps carry across the pair and touch no flag
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flags_and_data_addressing (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_resetn,
  input  wire cpu_flags_pkg::op_type      i_op,
  input  wire logic [7:0]                 i_mem_rdata,
  input  wire logic                       i_wdt_expire,
  output var  cpu_flags_pkg::mem_req_type o_mem,
  output var  logic                       o_busy,
  output var  logic                       o_branch,
  output var  logic [19:0]                o_branch_target,
  output var  logic [7:0]                 o_flags,
  output var  logic [7:0]                 o_working
);
  import cpu_flags_pkg::*;

  core_state_type state_q, state_d;
  op_type         op_q;
  logic [7:0]     working_q, flags_q, flags_d, saved_flags_q, saved_work_q;
  logic [5:0]     bank_q, saved_bank_q;
  logic [13:0]    tgt_q, dir_addr, eff_addr;
  logic           tgt_null_q, eff_null, take, in_exec, rd_ext_d, branch_op;
  ptr_adj_type    adj_q, eff_adj;
  logic [1:0]     adj_idx_q;
  logic [13:0]    ptr_tab [4];
  logic [NUM_PTRS-1:0] ptr_wr_lo, ptr_wr_hi;
  ptr_adj_type    ptr_adj [NUM_PTRS];
  logic [7:0]     rd_val, src, alu_res, flag_mask, calc_flags, addend;
  logic [8:0]     sum9;
  logic [4:0]     nib5;
  logic           wr_f, dest_is_f, wr_flags_dest, tgt_int;

  function automatic logic in_ptr_region(input logic [13:0] a);
    return a[13:5] == PTR_REGION && a[4:3] != PTR_NONE_IDX;
  endfunction : in_ptr_region

  function automatic logic is_virtual(input logic [13:0] a);
    return in_ptr_region(a) && a[2:0] >= PTR_OFS_IND && a[2:0] <= PTR_OFS_WOFS;
  endfunction : is_virtual

  function automatic logic is_internal(input logic [13:0] a);
    return a == ADDR_BANK || a == ADDR_WORK || a == ADDR_FLAGS ||
           a == ADDR_SAVED_FLAGS || a == ADDR_SAVED_WORK ||
           a == ADDR_SAVED_BANK || (in_ptr_region(a) && a[2:0] <= PTR_OFS_HI);
  endfunction : is_internal

  assign take      = state_q == ST_IDLE && i_op.valid;
  assign in_exec   = state_q == ST_EXEC;
  assign branch_op = i_op.fn == FN_CALL || i_op.fn == FN_GOTO || i_op.fn == FN_NOP;

  // three pointers, indexable by address bits [4:3]
  for (genvar g = 0; g < NUM_PTRS; g++) begin : g_ptr
    pointer_pair u_ptr (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_wr_lo    (ptr_wr_lo[g]),
      .i_wr_hi    (ptr_wr_hi[g]),
      .i_wdata    (alu_res),
      .i_adj      (ptr_adj[g]),
      .o_ptr      (ptr_tab[g])
    );
    assign ptr_wr_lo[g] = wr_f && in_ptr_region(tgt_q) && tgt_q[4:3] == 2'(g)
                          && tgt_q[2:0] == PTR_OFS_LO;
    assign ptr_wr_hi[g] = wr_f && in_ptr_region(tgt_q) && tgt_q[4:3] == 2'(g)
                          && tgt_q[2:0] == PTR_OFS_HI;
    assign ptr_adj[g]   = (in_exec && adj_idx_q == 2'(g)) ? adj_q : ADJ_NONE;
  end
  assign ptr_tab[3] = 14'h0000;

  // address formation for the operation being taken
  always_comb begin
    if (i_op.long_en) begin
      dir_addr = i_op.long_addr;
    end else if (i_op.access_sel) begin
      dir_addr = {bank_q, i_op.f_addr};
    end else if (i_op.f_addr < ACCESS_SPLIT) begin
      dir_addr = {ACCESS_LO_BANK, i_op.f_addr};
    end else begin
      dir_addr = {ACCESS_HI_BANK, i_op.f_addr};
    end
    eff_addr = dir_addr;
    eff_adj  = ADJ_NONE;
    eff_null = 1'b0;
    if (is_virtual(dir_addr)) begin
      // pointer value replaces the whole address, bank plays no part
      eff_addr = ptr_tab[dir_addr[4:3]];
      case (dir_addr[2:0])
        PTR_OFS_PINC: eff_adj = ADJ_INC;
        PTR_OFS_PDEC: eff_adj = ADJ_DEC;
        PTR_OFS_PRE: begin
          eff_addr = ptr_tab[dir_addr[4:3]] + 14'h0001;
          eff_adj  = ADJ_INC;
        end
        PTR_OFS_WOFS: eff_addr = ptr_tab[dir_addr[4:3]] + {{6{working_q[7]}}, working_q};
        default: eff_adj = ADJ_NONE;
      endcase
      // a pointer aimed at a virtual operand reads zero and writes nothing
      eff_null = is_virtual(eff_addr);
    end
  end

  assign rd_ext_d = take && !branch_op && !i_op.literal_en && i_op.fn != FN_MOVWF
                    && i_op.fn != FN_CLR && !eff_null && !is_internal(eff_addr);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (take && !branch_op) state_d = ST_READ;
      ST_READ: state_d = ST_EXEC;
      ST_EXEC: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
      o_busy  <= 1'b0;
    end else begin
      state_q <= state_d;
      o_busy  <= state_d != ST_IDLE;
    end
  end

  // operation capture
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      op_q       <= '0;
      tgt_q      <= 14'h0000;
      tgt_null_q <= 1'b0;
      adj_q      <= ADJ_NONE;
      adj_idx_q  <= PTR_NONE_IDX;
    end else if (take) begin
      op_q       <= i_op;
      tgt_q      <= eff_addr;
      tgt_null_q <= eff_null;
      adj_q      <= eff_null ? ADJ_NONE : eff_adj;
      adj_idx_q  <= is_virtual(dir_addr) ? dir_addr[4:3] : PTR_NONE_IDX;
    end
  end

  // call and goto target
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_branch        <= 1'b0;
      o_branch_target <= 20'h00000;
    end else begin
      o_branch <= take && (i_op.fn == FN_CALL || i_op.fn == FN_GOTO);
      if (take && (i_op.fn == FN_CALL || i_op.fn == FN_GOTO)) begin
        o_branch_target <= i_op.target;
      end
    end
  end

  // operand: internal register, external memory, or literal
  assign tgt_int = is_internal(tgt_q);
  always_comb begin
    rd_val = i_mem_rdata;
    if (tgt_null_q) begin
      rd_val = 8'h00;
    end else if (in_ptr_region(tgt_q) && tgt_q[2:0] == PTR_OFS_LO) begin
      rd_val = ptr_tab[tgt_q[4:3]][7:0];
    end else if (in_ptr_region(tgt_q) && tgt_q[2:0] == PTR_OFS_HI) begin
      rd_val = {2'b00, ptr_tab[tgt_q[4:3]][13:8]};
    end else begin
      case (tgt_q)
        ADDR_BANK:        rd_val = {2'b00, bank_q};
        ADDR_WORK:        rd_val = working_q;
        ADDR_FLAGS:       rd_val = {1'b0, flags_q[6:0]};
        ADDR_SAVED_FLAGS: rd_val = saved_flags_q;
        ADDR_SAVED_WORK:  rd_val = saved_work_q;
        ADDR_SAVED_BANK:  rd_val = {2'b00, saved_bank_q};
        default:          rd_val = i_mem_rdata;
      endcase
    end
  end
  assign src = op_q.literal_en ? op_q.literal : rd_val;

  // subtract is an add of the inverted working register plus one
  assign addend = (op_q.fn == FN_SUB) ? ~working_q : working_q;
  assign sum9 = {1'b0, src} + {1'b0, addend} + {8'h00, op_q.fn == FN_SUB};
  assign nib5 = {1'b0, src[3:0]} + {1'b0, addend[3:0]} + {4'h0, op_q.fn == FN_SUB};

  always_comb begin
    alu_res    = src;
    flag_mask  = MASK_NONE;
    calc_flags = 8'h00;
    calc_flags[FLAG_C] = flags_q[FLAG_C];
    case (op_q.fn)
      FN_ADD, FN_SUB: begin
        alu_res             = sum9[7:0];
        flag_mask           = MASK_ARITH;
        calc_flags[FLAG_C]  = sum9[8];
        calc_flags[FLAG_DC] = nib5[4];
        calc_flags[FLAG_OV] = (src[7] == addend[7]) && (sum9[7] != src[7]);
      end
      FN_AND:  begin alu_res = src & working_q; flag_mask = MASK_LOGIC; end
      FN_IOR:  begin alu_res = src | working_q; flag_mask = MASK_LOGIC; end
      FN_XOR:  begin alu_res = src ^ working_q; flag_mask = MASK_LOGIC; end
      FN_MOVF: flag_mask = MASK_LOGIC;
      FN_CLR:  begin alu_res = 8'h00; flag_mask = MASK_LOGIC; end
      FN_RLC: begin
        alu_res            = {src[6:0], flags_q[FLAG_C]};
        flag_mask          = MASK_ROTATE;
        calc_flags[FLAG_C] = src[7];
      end
      FN_RRC: begin
        alu_res            = {flags_q[FLAG_C], src[7:1]};
        flag_mask          = MASK_ROTATE;
        calc_flags[FLAG_C] = src[0];
      end
      FN_SWAP:  alu_res = {src[3:0], src[7:4]};
      FN_BSF:   alu_res = src | (8'h01 << op_q.bit_sel);
      FN_BCF:   alu_res = src & ~(8'h01 << op_q.bit_sel);
      FN_MOVWF: alu_res = working_q;
      default:  alu_res = src;
    endcase
    calc_flags[FLAG_Z] = alu_res == 8'h00;
    calc_flags[FLAG_N] = alu_res[7];
  end

  assign dest_is_f = (op_q.dest_f && !op_q.literal_en) || op_q.fn == FN_MOVWF ||
                     op_q.fn == FN_CLR || op_q.fn == FN_BSF || op_q.fn == FN_BCF;
  assign wr_f = in_exec && dest_is_f && !tgt_null_q;
  assign wr_flags_dest = wr_f && tgt_q == ADDR_FLAGS;

  always_comb begin
    flags_d = flags_q;
    if (wr_flags_dest && flag_mask == MASK_NONE) begin
      flags_d = (flags_q & ~FLAGS_SW_MASK) | (alu_res & FLAGS_SW_MASK);
    end
    // a flag-affecting op aimed at the flags keeps only its flag updates
    flags_d = (flags_d & ~flag_mask) | (calc_flags & flag_mask);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      flags_q <= FLAGS_RESET;
    end else begin
      if (in_exec) flags_q <= flags_d;
      if (take && i_op.wdt_clear) begin
        flags_q[FLAG_TO] <= 1'b1;
        flags_q[FLAG_PD] <= 1'b1;
      end
      if (take && i_op.sleep) begin
        flags_q[FLAG_TO] <= 1'b1;
        flags_q[FLAG_PD] <= 1'b0;
      end
      if (i_wdt_expire) flags_q[FLAG_TO] <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      working_q <= 8'h00;
      bank_q    <= 6'h00;
    end else if (in_exec) begin
      if (!dest_is_f || (wr_f && tgt_q == ADDR_WORK)) working_q <= alu_res;
      if (wr_f && tgt_q == ADDR_BANK) bank_q <= alu_res[BANK_BITS-1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      saved_flags_q <= 8'h00;
      saved_work_q  <= 8'h00;
      saved_bank_q  <= 6'h00;
    end else if (take && i_op.fn == FN_CALL) begin
      saved_flags_q <= {1'b0, flags_q[6:0]};
      saved_work_q  <= working_q;
      saved_bank_q  <= bank_q;
    end
  end

  // memory strobes: read one cycle after take, write one cycle after exec
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_mem <= '0;
    end else begin
      o_mem.rd <= rd_ext_d;
      o_mem.wr <= wr_f && !tgt_int;
      if (rd_ext_d) o_mem.addr <= eff_addr;
      if (wr_f && !tgt_int) begin
        o_mem.addr  <= tgt_q;
        o_mem.wdata <= alu_res;
      end
    end
  end

  assign o_flags   = flags_q;
  assign o_working = working_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  a_flags_top_zero: assert property (o_flags[FLAG_UNUSED] == 1'b0)
    else $error("flags bit 7 is set");
  a_flags_dest_drop: assert property (
    in_exec && wr_flags_dest && flag_mask != MASK_NONE
      |=> ((o_flags ^ $past(calc_flags)) & $past(flag_mask)) == 8'h00 && !o_mem.wr)
    else $error("flags destination did not take computed flags");
  a_call_saves: assert property (
    take && i_op.fn == FN_CALL |=> saved_work_q == $past(working_q)
      && saved_bank_q == $past(bank_q) && saved_flags_q == $past(flags_q))
    else $error("call did not save context");
  a_timeout_clear: assert property (i_wdt_expire |=> !o_flags[FLAG_TO])
    else $error("timeout flag not cleared on expiry");
  a_sleep_powerdown: assert property (
    take && i_op.sleep && !i_op.wdt_clear
      |=> !o_flags[FLAG_PD] && (o_flags[FLAG_TO] || $past(i_wdt_expire)))
    else $error("sleep did not update power-down and timeout flags");
  a_zero_flag: assert property (
    in_exec && flag_mask[FLAG_Z] |=> o_flags[FLAG_Z] == ($past(alu_res) == 8'h00))
    else $error("zero flag wrong");
  a_add_carry: assert property (
    in_exec && op_q.fn == FN_ADD |=> o_flags[FLAG_C] == $past(sum9[8]))
    else $error("add carry wrong");
  a_sub_borrow: assert property (
    in_exec && op_q.fn == FN_SUB |=> o_flags[FLAG_C] == ($past(src) >= $past(working_q)))
    else $error("subtract carry is not the inverted borrow");
  a_long_addr: assert property (
    rd_ext_d && i_op.long_en |=> o_mem.rd && o_mem.addr == $past(i_op.long_addr))
    else $error("long address not used as given");
  a_banked_addr: assert property (
    rd_ext_d && !i_op.long_en && i_op.access_sel && !is_virtual(dir_addr)
      |=> o_mem.addr == {$past(bank_q), $past(i_op.f_addr)})
    else $error("banked address wrong");
  a_indirect_target: assert property (
    rd_ext_d && is_virtual(dir_addr) && dir_addr[2:0] == PTR_OFS_IND
      |=> o_mem.rd && o_mem.addr == $past(ptr_tab[dir_addr[4:3]]))
    else $error("indirect read not at pointer address");
  a_dest_working: assert property (
    in_exec && !dest_is_f |=> o_working == $past(alu_res) && !o_busy)
    else $error("working register not written");

  c_call: cover property (take && i_op.fn == FN_CALL);
  c_flags_dest: cover property (in_exec && wr_flags_dest);
  c_post_inc: cover property (in_exec && adj_q == ADJ_INC);
  c_sleep: cover property (take && i_op.sleep);

endmodule : cpu_status_flags_and_data_addressing
`default_nettype wire

// >>> hdl/pointer_pair.sv
/*
  One 14-bit indirect pointer made of a low and a high byte register,
  with direct byte writes and automatic step by one.
  Assumes the owner never asks for a byte write and a step on another pointer.
*/
`timescale 1ns/1ps
`default_nettype none
module pointer_pair (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_wr_lo,
  input  wire logic                      i_wr_hi,
  input  wire logic [7:0]                i_wdata,
  input  wire cpu_flags_pkg::ptr_adj_type i_adj,
  output var  logic [13:0]               o_ptr
);
  import cpu_flags_pkg::*;

  // a byte write wins over a pending step; top two high bits do not exist
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_ptr <= 14'h0000;
    end else if (i_wr_lo) begin
      o_ptr[7:0] <= i_wdata;
    end else if (i_wr_hi) begin
      o_ptr[13:8] <= i_wdata[5:0];
    end else begin
      case (i_adj)
        ADJ_INC: o_ptr <= o_ptr + 14'h0001;
        ADJ_DEC: o_ptr <= o_ptr - 14'h0001;
        default: o_ptr <= o_ptr;
      endcase
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  a_ptr_step_pair: assert property (
    (i_adj == ADJ_INC && !i_wr_lo && !i_wr_hi && o_ptr[7:0] == 8'hff)
      |=> o_ptr[7:0] == 8'h00 && o_ptr[13:8] == $past(o_ptr[13:8]) + 6'h01)
    else $error("pointer increment did not carry into the high byte");

endmodule : pointer_pair
`default_nettype wire

// >>> verification/data_mem_model.sv
/*
  Data memory model on the far side of the core: a byte array that answers
  a read in the cycle after the strobe and stores every write strobe.
  Assumes one clock and the core's mem_req_type strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
  input  wire logic                       i_core_clk,
  input  wire cpu_flags_pkg::mem_req_type i_mem,
  output var  logic [7:0]                 o_rdata
);
  import cpu_flags_pkg::*;
  logic [7:0] mem_q [16384];
  initial o_rdata = 8'h00;
  // read data stands one cycle only, then scrambles so stale data cannot pass
  always @(posedge i_core_clk) begin
    o_rdata <= i_mem.rd ? mem_q[i_mem.addr] : ~o_rdata;
    if (i_mem.wr) begin
      mem_q[i_mem.addr] <= i_mem.wdata;
    end
  end
endmodule : data_mem_model
`default_nettype wire

// >>> verification/tb.sv
/*
  Self-checking bench for the flag and data-addressing core.
  Assumes the data memory model beside it and one 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cpu_flags_pkg::*;
  logic        clk, resetn, wdt, busy, br;
  op_type      op;
  mem_req_type mem;
  logic [7:0]  rdata, flags, work;
  logic [19:0] tgt;
  int          err_count, checked;
  cpu_status_flags_and_data_addressing i_cpu_status_flags_and_data_addressing (
    .i_core_clk(clk), .i_resetn(resetn), .i_op(op), .i_mem_rdata(rdata),
    .i_wdt_expire(wdt), .o_mem(mem), .o_busy(busy), .o_branch(br),
    .o_branch_target(tgt), .o_flags(flags), .o_working(work));
  data_mem_model i_data_mem_model (.i_core_clk(clk), .i_mem(mem), .o_rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(logic [19:0] got, logic [19:0] exp, string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  function automatic op_type mk(alu_fn_type fn, logic [7:0] f, logic a, logic d);
    mk = '0;
    mk.fn = fn;
    mk.f_addr = f;
    mk.access_sel = a;
    mk.dest_f = d;
  endfunction : mk
  // expected n, ov, z, dc, c of an add with carry in
  function automatic logic [4:0] af(logic [7:0] a, logic [7:0] b, logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
  endfunction : af
  task automatic run(op_type o);
    int n;
    @(negedge clk);
    op = o;
    op.valid = 1'b1;
    @(negedge clk);
    op = '0;
    n = 0;
    while (busy === 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask : run
  task automatic ldw(logic [7:0] v);
    i_data_mem_model.mem_q[14'h0020] = v;
    run(mk(FN_MOVF, 8'h20, 1'b0, 1'b0));
  endtask : ldw
  task automatic t_arith();
    logic [7:0] fv[5] = '{8'h7f, 8'hff, 8'h0f, 8'h03, 8'h80};
    logic [7:0] wv[5] = '{8'h01, 8'h01, 8'h01, 8'h05, 8'h01};
    for (int i = 0; i < 5; i++) begin
      i_data_mem_model.mem_q[14'h0030] = fv[i];
      ldw(wv[i]);
      run(mk(FN_ADD, 8'h30, 1'b0, 1'b0));
      chk(work, 8'(fv[i] + wv[i]), "add result");
      chk(flags[4:0], af(fv[i], wv[i], 1'b0), "add flags");
      ldw(wv[i]);
      run(mk(FN_SUB, 8'h30, 1'b0, 1'b0));
      chk(work, 8'(fv[i] - wv[i]), "sub result");
      chk(flags[4:0], af(fv[i], ~wv[i], 1'b1), "sub flags");
    end
  endtask : t_arith
  task automatic t_rotate();
    i_data_mem_model.mem_q[14'h0030] = 8'h81;
    run(mk(FN_RLC, 8'h30, 1'b0, 1'b0));
    chk({work, flags[0]}, 9'h007, "rotate left");
    i_data_mem_model.mem_q[14'h0030] = 8'h02;
    run(mk(FN_RRC, 8'h30, 1'b0, 1'b0));
    chk({work, flags[0]}, 9'h102, "rotate right");
  endtask : t_rotate
  task automatic t_addr();
    op_type o;
    ldw(8'h02);
    run(mk(FN_MOVWF, 8'hd8, 1'b0, 1'b1));
    i_data_mem_model.mem_q[14'h0210] = 8'h11;
    i_data_mem_model.mem_q[14'h0010] = 8'h21;
    i_data_mem_model.mem_q[14'h3f70] = 8'h31;
    i_data_mem_model.mem_q[14'h1234] = 8'h5a;
    run(mk(FN_ADD, 8'h10, 1'b1, 1'b1));
    chk(i_data_mem_model.mem_q[14'h0210], 8'h13, "banked write");
    run(mk(FN_ADD, 8'h10, 1'b0, 1'b1));
    chk(i_data_mem_model.mem_q[14'h0010], 8'h23, "access low");
    run(mk(FN_ADD, 8'h70, 1'b0, 1'b1));
    chk(i_data_mem_model.mem_q[14'h3f70], 8'h33, "access high");
    o = mk(FN_MOVF, 8'h00, 1'b1, 1'b0);
    o.long_en = 1'b1;
    o.long_addr = 14'h1234;
    run(o);
    chk(work, 8'h5a, "long address");
  endtask : t_addr
  task automatic t_flagdest();
    ldw(8'h00);
    run(mk(FN_MOVWF, 8'hda, 1'b0, 1'b1));
    run(mk(FN_CLR, 8'hda, 1'b0, 1'b1));
    chk(flags, 8'h64, "clear of flags");
    ldw(8'hff);
    run(mk(FN_MOVWF, 8'hda, 1'b0, 1'b1));
    chk(flags, 8'h7f, "move to flags");
  endtask : t_flagdest
  task automatic t_call();
    op_type o;
    ldw(8'h3c);
    o = mk(FN_CALL, 8'h00, 1'b0, 1'b0);
    o.target = 20'habcde;
    o.valid = 1'b1;
    @(negedge clk);
    op = o;
    @(negedge clk);
    op = '0;
    chk({br, tgt}, 21'h1abcde, "call target");
    run(mk(FN_MOVF, 8'hdc, 1'b0, 1'b0));
    chk(work, 8'h3c, "saved working");
    run(mk(FN_MOVF, 8'hdd, 1'b0, 1'b0));
    chk(work, 8'h02, "saved bank");
    run(mk(FN_MOVF, 8'hdb, 1'b0, 1'b0));
    chk(work, 8'h6b, "saved flags");
  endtask : t_call
  task automatic t_power();
    op_type o;
    o = mk(FN_NOP, 8'h00, 1'b0, 1'b0);
    o.sleep = 1'b1;
    run(o);
    chk(flags[6:5], 2'b10, "sleep");
    wdt = 1'b1;
    @(negedge clk);
    wdt = 1'b0;
    @(negedge clk);
    chk(flags[6], 1'b0, "expiry");
    o.sleep = 1'b0;
    o.wdt_clear = 1'b1;
    run(o);
    chk(flags[6:5], 2'b11, "watchdog clear");
  endtask : t_power
  task automatic t_ptr();
    logic [7:0] f[7] = '{8'hc3, 8'hc2, 8'hc5, 8'hc4, 8'hc2, 8'hc1, 8'hc6};
    logic [7:0] e[7] = '{8'h91, 8'h92, 8'h93, 8'h93, 8'h92, 8'h01, 8'h93};
    i_data_mem_model.mem_q[14'h00ff] = 8'h91;
    i_data_mem_model.mem_q[14'h0100] = 8'h92;
    i_data_mem_model.mem_q[14'h0101] = 8'h93;
    ldw(8'hff);
    run(mk(FN_MOVWF, 8'hc0, 1'b0, 1'b1));
    ldw(8'h00);
    run(mk(FN_MOVWF, 8'hc1, 1'b0, 1'b1));
    for (int i = 0; i < 7; i++) begin
      run(mk(FN_MOVF, f[i], 1'b0, 1'b0));
      chk(work, e[i], "pointer access");
    end
  endtask : t_ptr
  task automatic results();
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  initial begin
    #200000;
    err_count++;
    results();
  end
  initial begin
    op = '0;
    wdt = 1'b0;
    resetn = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    chk(flags, 8'h60, "reset flags");
    t_arith();
    t_rotate();
    t_addr();
    t_flagdest();
    t_call();
    t_power();
    t_ptr();
    results();
  end
endmodule : tb
`default_nettype wire
